// >>> hdl/sdp_consts.vh
/*
  Constants for the static digital port register block: offsets, field
  positions, reset values and port count.
  Assumes it is included by bare name from the design file.
*/
`ifndef SDP_CONSTS_VH
`define SDP_CONSTS_VH

// ----------------------------------------------------------------------
// Geometry
// ----------------------------------------------------------------------
`define SDP_NUM_PORTS      12
`define SDP_PORT_STRIDE    8'h10
`define SDP_ADDR_W         8
`define SDP_DATA_W         8

// ----------------------------------------------------------------------
// Per-port register addresses of port 0; each further port adds one stride
// ----------------------------------------------------------------------
`define SDP_OFF_DATA       8'h40
`define SDP_OFF_DIR        8'h41
`define SDP_OFF_RISE       8'h42
`define SDP_OFF_FALL       8'h43
`define SDP_OFF_FILT       8'h44
`define SDP_OFF_TRI        8'h46
`define SDP_OFF_SAFE       8'h47
`define SDP_OFF_LEVEL      8'h48

// ----------------------------------------------------------------------
// Board-level registers
// ----------------------------------------------------------------------
`define SDP_OFF_CLEAR      8'h01
`define SDP_OFF_IRQ_STAT   8'h02
`define SDP_OFF_IRQ_EN     8'h03
`define SDP_OFF_IRQ_CLR    8'h05
`define SDP_OFF_EXP_STAT   8'h17

// ----------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------
`define SDP_BIT_CTRL       0
`define SDP_BIT_EXP_CLEAR  4
`define SDP_BIT_IRQ_RISE   0
`define SDP_BIT_IRQ_FALL   1
`define SDP_BIT_IRQ_EXP    2
`define SDP_IRQ_W          3

// ----------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------
`define SDP_RST_REG        8'h00
`define SDP_RST_IRQ        3'h0

`endif

// >>> hdl/sdp_port_regs.v
/*
  Per-port register set of a static digital I/O board: data, direction,
  edge monitor masks, filter masks and guard timer expiry behaviour for
  twelve eight-line ports, plus sticky event status with an interrupt.
  Assumes: single clock, a plain strobe register port, an external guard
  timer that signals expiry, an external filter interval tick and an
  external board-level pad ring resolving output enables.
*/
// The plain strobed port was chosen for this implementation.
// Functional notes
// - Twelve port register copies, sixteen bytes apart
// - Data read gives line levels, write drives
// - Direction bit 0: 0 input, 1 output
// - Rise mask enables low-to-high monitoring
// - Fall mask enables high-to-low monitoring
// - Filter mask enables filter, shared interval
// - Tristate bit picks high-Z or levels
// - Expiry actions need guard timer enabled
// - Tristate choice only on bidirectional ports
// - Safe-state enable applies expiry safe state
// - Safe-state enable ignored on input-only ports
// - Level bit sets each line's expiry level
// - Levels apply only with tristate bit zero
// - Safe state holds until expiry clear
`timescale 1ns/1ns
`default_nettype none
`include "sdp_consts.vh"

module sdp_port_regs #(
  // Per-port kind, two bits each: 0 bidirectional, 1 input, 2 output
  parameter [2*`SDP_NUM_PORTS-1:0] PORT_KIND = {2*`SDP_NUM_PORTS{1'b0}}
) (
  // Clock and reset
  input  wire                        clk_i,
  input  wire                        rst_i,
  // Register port
  input  wire [`SDP_ADDR_W-1:0]      addr_i,
  input  wire [`SDP_DATA_W-1:0]      wdata_i,
  input  wire                        wr_i,
  input  wire                        rd_i,
  output reg  [`SDP_DATA_W-1:0]      rdata_o,
  // Guard timer and filter interval
  input  wire                        guard_timer_enable_i,
  input  wire                        guard_timer_expired_i,
  input  wire                        filter_tick_i,
  // Field lines
  input  wire [8*`SDP_NUM_PORTS-1:0] line_i,
  output reg  [8*`SDP_NUM_PORTS-1:0] line_o,
  output reg  [8*`SDP_NUM_PORTS-1:0] line_oe_o,
  // Edge reports and interrupt
  output reg  [8*`SDP_NUM_PORTS-1:0] rise_edge_o,
  output reg  [8*`SDP_NUM_PORTS-1:0] fall_edge_o,
  output wire                        irq_o
);

  localparam NP = `SDP_NUM_PORTS;
  localparam NL = 8 * `SDP_NUM_PORTS;

  // --------------------------------------------------------------------
  // Helpers
  // --------------------------------------------------------------------
  // Port slot of an address, or NP when outside the port window
  function [3:0] sdp_port_of;
    input [`SDP_ADDR_W-1:0] a;
    reg   [`SDP_ADDR_W-1:0] rel;
    begin
      rel = a - `SDP_OFF_DATA;
      if (a < `SDP_OFF_DATA || rel[7:4] >= NP[3:0]) begin
        sdp_port_of = NP[3:0];
      end else begin
        sdp_port_of = rel[7:4];
      end
    end
  endfunction

  // Register slot within a port (low nibble of offset)
  function [3:0] sdp_slot_of;
    input [`SDP_ADDR_W-1:0] a;
    begin
      sdp_slot_of = a[3:0];
    end
  endfunction

  // Port kind tests; fixed-direction ports ignore the direction bit
  function sdp_is_in;
    input integer p;
    begin
      sdp_is_in = (PORT_KIND[2*p +: 2] == 2'd1);
    end
  endfunction

  function sdp_is_out;
    input integer p;
    begin
      sdp_is_out = (PORT_KIND[2*p +: 2] == 2'd2);
    end
  endfunction

  // --------------------------------------------------------------------
  // Storage
  // --------------------------------------------------------------------
  reg [7:0] port_data               [0:NP-1];
  reg [7:0] port_direction          [0:NP-1];
  reg [7:0] rise_detect_mask        [0:NP-1];
  reg [7:0] fall_detect_mask        [0:NP-1];
  reg [7:0] input_filter_mask       [0:NP-1];
  reg [7:0] expiry_tristate_select  [0:NP-1];
  reg [7:0] expiry_safe_state_enable[0:NP-1];
  reg [7:0] expiry_line_levels      [0:NP-1];

  reg [NL-1:0] line_meta;
  reg [NL-1:0] line_sync;
  reg [NL-1:0] line_filt;
  reg [NL-1:0] line_prev;
  reg [NL-1:0] line_cand;
  reg [NL-1:0] line_steady;
  reg          en_meta;
  reg          en_sync;
  reg          exp_meta;
  reg          exp_sync;
  reg          tick_meta;
  reg          tick_sync;
  reg          expired;
  reg [`SDP_IRQ_W-1:0] irq_status;
  reg [`SDP_IRQ_W-1:0] irq_enable;

  wire [3:0] wr_port = sdp_port_of(addr_i);
  wire [3:0] wr_slot = sdp_slot_of(addr_i);
  wire       exp_clear = wr_i && addr_i == `SDP_OFF_CLEAR &&
                         wdata_i[`SDP_BIT_EXP_CLEAR];

  integer i;

  // --------------------------------------------------------------------
  // Synchronisers for pins and outside timer levels
  // --------------------------------------------------------------------
  // Two flops each; only the second stage is read
  // Costs two cycles on every pin, but no metastable level reaches logic
  always @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      line_meta <= {NL{1'b0}};
      line_sync <= {NL{1'b0}};
      en_meta   <= 1'b0;
      en_sync   <= 1'b0;
      exp_meta  <= 1'b0;
      exp_sync  <= 1'b0;
      tick_meta <= 1'b0;
      tick_sync <= 1'b0;
    end else begin
      line_meta <= line_i;
      line_sync <= line_meta;
      en_meta   <= guard_timer_enable_i;
      en_sync   <= en_meta;
      exp_meta  <= guard_timer_expired_i;
      exp_sync  <= exp_meta;
      tick_meta <= filter_tick_i;
      tick_sync <= tick_meta;
    end
  end

  // --------------------------------------------------------------------
  // Register writes
  // --------------------------------------------------------------------
  // All copies reset to zero: input, no monitoring, no expiry action
  // Reserved bits are stored as written; only bit 0 of controls acts
  always @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      for (i = 0; i < NP; i = i + 1) begin
        port_data[i]                <= `SDP_RST_REG;
        port_direction[i]           <= `SDP_RST_REG;
        rise_detect_mask[i]         <= `SDP_RST_REG;
        fall_detect_mask[i]         <= `SDP_RST_REG;
        input_filter_mask[i]        <= `SDP_RST_REG;
        expiry_tristate_select[i]   <= `SDP_RST_REG;
        expiry_safe_state_enable[i] <= `SDP_RST_REG;
        expiry_line_levels[i]       <= `SDP_RST_REG;
      end
    end else if (wr_i && wr_port != NP[3:0]) begin
      // Slot decode repeats every stride bytes
      case (wr_slot)
        4'h0: port_data[wr_port]                <= wdata_i;
        4'h1: port_direction[wr_port]           <= wdata_i;
        4'h2: rise_detect_mask[wr_port]         <= wdata_i;
        4'h3: fall_detect_mask[wr_port]         <= wdata_i;
        4'h4: input_filter_mask[wr_port]        <= wdata_i;
        4'h6: expiry_tristate_select[wr_port]   <= wdata_i;
        4'h7: expiry_safe_state_enable[wr_port] <= wdata_i;
        4'h8: expiry_line_levels[wr_port]       <= wdata_i;
        default: ;
      endcase
    end
  end

  // --------------------------------------------------------------------
  // Expiry latch
  // --------------------------------------------------------------------
  // Expiry only counts while the timer is enabled; a fresh expiry wins
  // over a clear in the same cycle so none is lost
  // The latch outlives the timer inputs: the safe state stays until
  // software clears it, even if the timer is disabled meanwhile
  always @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      expired <= 1'b0;
    end else if (en_sync && exp_sync) begin
      expired <= 1'b1;
    end else if (exp_clear) begin
      expired <= 1'b0;
    end
  end

  // --------------------------------------------------------------------
  // Input filter
  // --------------------------------------------------------------------
  // A filtered line must hold one level from one shared tick to the
  // next before it passes; any change in between spoils the interval.
  // Costs up to two intervals of delay, but every pulse shorter than an
  // interval is rejected. Unfiltered lines pass straight through.
  always @(posedge clk_i or posedge rst_i) begin : sdp_filter_proc
    integer i;
    if (rst_i) begin
      line_filt   <= {NL{1'b0}};
      line_cand   <= {NL{1'b0}};
      line_steady <= {NL{1'b1}};
    end else begin
      for (i = 0; i < NL; i = i + 1) begin
        if (!input_filter_mask[i/8][i%8]) begin
          line_filt[i]   <= line_sync[i];
          line_cand[i]   <= line_sync[i];
          line_steady[i] <= 1'b1;
        end else if (tick_sync) begin
          // Pass only a level that held through the whole interval
          if (line_steady[i] && line_sync[i] == line_cand[i]) begin
            line_filt[i] <= line_cand[i];
          end
          // Open the next interval at the present level
          line_cand[i]   <= line_sync[i];
          line_steady[i] <= 1'b1;
        end else if (line_sync[i] != line_cand[i]) begin
          // Glitch inside the interval: it can no longer pass
          line_cand[i]   <= line_sync[i];
          line_steady[i] <= 1'b0;
        end
      end
    end
  end

  // --------------------------------------------------------------------
  // Edge detection
  // --------------------------------------------------------------------
  // One-cycle reports, gated per line by the monitor masks
  // Edges are taken after the filter, so a rejected glitch never reports
  always @(posedge clk_i or posedge rst_i) begin : sdp_edge_proc
    integer i;
    if (rst_i) begin
      line_prev   <= {NL{1'b0}};
      rise_edge_o <= {NL{1'b0}};
      fall_edge_o <= {NL{1'b0}};
    end else begin
      line_prev <= line_filt;
      for (i = 0; i < NL; i = i + 1) begin
        rise_edge_o[i] <= line_filt[i] & ~line_prev[i] &
                          rise_detect_mask[i/8][i%8];
        fall_edge_o[i] <= ~line_filt[i] & line_prev[i] &
                          fall_detect_mask[i/8][i%8];
      end
    end
  end

  // --------------------------------------------------------------------
  // Pin drive
  // --------------------------------------------------------------------
  // Direction only counts on bidirectional ports; reserved direction
  // bits are ignored, trusting software to keep them zero
  always @(posedge clk_i or posedge rst_i) begin : sdp_drive_proc
    integer i;
    if (rst_i) begin
      line_o    <= {NL{1'b0}};
      line_oe_o <= {NL{1'b0}};
    end else begin
      for (i = 0; i < NP; i = i + 1) begin
        if (sdp_is_in(i)) begin
          // Input-only: never driven, expiry enable ignored
          line_o[8*i +: 8]    <= 8'h00;
          line_oe_o[8*i +: 8] <= 8'h00;
        end else if (expired &&
                     expiry_safe_state_enable[i][`SDP_BIT_CTRL]) begin
          if (!sdp_is_out(i) &&
              expiry_tristate_select[i][`SDP_BIT_CTRL]) begin
            line_o[8*i +: 8]    <= 8'h00;
            line_oe_o[8*i +: 8] <= 8'h00;
          end else begin
            line_o[8*i +: 8]    <= expiry_line_levels[i];
            line_oe_o[8*i +: 8] <= 8'hff;
          end
        end else if (sdp_is_out(i)) begin
          // Fixed output: the direction register has no say
          line_o[8*i +: 8]    <= port_data[i];
          line_oe_o[8*i +: 8] <= 8'hff;
        end else begin
          line_o[8*i +: 8]    <= port_data[i];
          // Bidirectional: bit 0 turns the whole port around
          line_oe_o[8*i +: 8] <= {8{port_direction[i][`SDP_BIT_CTRL]}};
        end
      end
    end
  end

  // --------------------------------------------------------------------
  // Event status and interrupt
  // --------------------------------------------------------------------
  // Any masked edge on any line and the onset of expiry feed the status;
  // per-line detail is left to the edge outputs
  wire       any_rise = |rise_edge_o;
  wire       any_fall = |fall_edge_o;
  wire       exp_rise = en_sync & exp_sync & ~expired;
  wire [2:0] irq_set  = {exp_rise, any_fall, any_rise};
  wire       irq_clr_wr = wr_i && addr_i == `SDP_OFF_IRQ_CLR;

  // Set wins over a clear that lands in the same cycle
  always @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      irq_status <= `SDP_RST_IRQ;
      irq_enable <= `SDP_RST_IRQ;
    end else begin
      irq_status <= (irq_status & ~(irq_clr_wr ? wdata_i[2:0] : 3'h0)) |
                    irq_set;
      if (wr_i && addr_i == `SDP_OFF_IRQ_EN) begin
        irq_enable <= wdata_i[2:0];
      end
    end
  end

  // Level output: stays high until software clears or masks the cause
  assign irq_o = |(irq_status & irq_enable);

  // --------------------------------------------------------------------
  // Read path
  // --------------------------------------------------------------------
  // Data register reads the pin levels, not the stored value; unmapped
  // offsets and write-only registers read as zero
  // The strobe qualifies the data so a stale word never lingers
  always @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      rdata_o <= 8'h00;
    end else if (!rd_i) begin
      rdata_o <= 8'h00;
    end else if (wr_port != NP[3:0]) begin
      case (wr_slot)
        4'h0: rdata_o <= line_sync[8*wr_port +: 8];
        4'h1: rdata_o <= port_direction[wr_port];
        4'h2: rdata_o <= rise_detect_mask[wr_port];
        4'h3: rdata_o <= fall_detect_mask[wr_port];
        4'h4: rdata_o <= input_filter_mask[wr_port];
        4'h6: rdata_o <= expiry_tristate_select[wr_port];
        4'h7: rdata_o <= expiry_safe_state_enable[wr_port];
        4'h8: rdata_o <= expiry_line_levels[wr_port];
        default: rdata_o <= 8'h00;
      endcase
    end else begin
      case (addr_i)
        `SDP_OFF_IRQ_STAT: rdata_o <= {5'h00, irq_status};
        `SDP_OFF_IRQ_EN:   rdata_o <= {5'h00, irq_enable};
        `SDP_OFF_EXP_STAT: rdata_o <= {7'h00, expired};
        default:           rdata_o <= 8'h00;
      endcase
    end
  end

endmodule // sdp_port_regs

`default_nettype wire

// >>> verif/sdp_port_regs_monitor.sv
/* Checker for sdp_port_regs, bound to its ports.
   Assumes one clock and an active-high asynchronous reset. */
`timescale 1ns/1ns
`default_nettype none
module sdp_port_regs_mon #(
  parameter [23:0] PORT_KIND = 24'h000000
) (
  // Clock, reset, register port
  input wire logic        clk_i,
  input wire logic        rst_i,
  input wire logic [7:0]  addr_i,
  input wire logic [7:0]  wdata_i,
  input wire logic        wr_i,
  input wire logic        rd_i,
  input wire logic [7:0]  rdata_o,
  input wire logic        guard_timer_enable_i,
  // Line side
  input wire logic [95:0] line_o,
  input wire logic [95:0] line_oe_o,
  input wire logic [95:0] rise_edge_o,
  input wire logic [95:0] fall_edge_o,
  input wire logic        irq_o
);
  // Lines of input-only ports
  logic [95:0] in_mask;
  always_comb
    for (int p = 0; p < 12; p++)
      in_mask[8*p +: 8] = {8{PORT_KIND[2*p +: 2] == 2'h1}};
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  a_rdata_idle: assert property (!$past(rd_i) |-> rdata_o == 8'h00)
    else $error("read data outside its cycle");
  // Expiry may override the port, so only quiet guard timer counts
  a_data_drive: assert property (
    wr_i && addr_i == 8'h40 && !guard_timer_enable_i
    |-> ##2 (!line_oe_o[0] || line_o[7:0] == $past(wdata_i, 2)))
    else $error("port 0 drive value wrong");
  a_dir_output: assert property (
    wr_i && addr_i == 8'h41 && wdata_i[0] && !guard_timer_enable_i
    |-> ##2 line_oe_o[7:0] == 8'hff) else $error("port 0 not driving");
  a_edge_apart: assert property ((rise_edge_o & fall_edge_o) == 96'h0)
    else $error("rise and fall on one line");
  a_rise_gap: assert property ((rise_edge_o & $past(rise_edge_o)) == 96'h0)
    else $error("rise pulses back to back");
  a_fall_gap: assert property ((fall_edge_o & $past(fall_edge_o)) == 96'h0)
    else $error("fall pulses back to back");
  a_input_quiet: assert property ((line_oe_o & in_mask) == 96'h0)
    else $error("input-only port driven");
  a_reset_quiet: assert property ($fell(rst_i) |-> line_oe_o == 96'h0 && !irq_o)
    else $error("outputs active after reset");
  c_rise: cover property (|rise_edge_o[7:0]);
  c_fall: cover property (|fall_edge_o[7:0]);
  c_irq: cover property ($rose(irq_o));
endmodule // sdp_port_regs_mon
bind sdp_port_regs sdp_port_regs_mon #(.PORT_KIND(PORT_KIND)) u_mon (
  .clk_i(clk_i), .rst_i(rst_i), .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i),
  .rd_i(rd_i), .rdata_o(rdata_o), .guard_timer_enable_i(guard_timer_enable_i),
  .line_o(line_o), .line_oe_o(line_oe_o), .rise_edge_o(rise_edge_o),
  .fall_edge_o(fall_edge_o), .irq_o(irq_o));
`default_nettype wire

// >>> verif/sdp_field_model.sv
/* Field equipment on the port pins.
   Assumes the bench sets the level the field drives on each line. */
`timescale 1ns/1ns
`default_nettype none
module sdp_field_model (
  // Port side of the pins
  input  wire logic [95:0] line_o,
  input  wire logic [95:0] line_oe_o,
  // Field levels
  input  wire logic [95:0] field_val,
  // Resolved pins
  output wire logic [95:0] line_i
);
  // Field drives weakly, so a driving port wins the pin
  assign line_i = (line_oe_o & line_o) | (~line_oe_o & field_val);
endmodule // sdp_field_model
`default_nettype wire

// >>> verif/sdp_port_regs_tb.sv
/* Testbench for sdp_port_regs: registers, lines, edges, filter, expiry.
   Assumes the field model and the bound checker are compiled with it. */
`timescale 1ns/1ns
`default_nettype none
module sdp_port_regs_tb;
  // ----------
  // Signals
  // ----------
  logic        clk_i = 1'b0;
  logic        rst_i = 1'b1;
  logic [7:0]  addr_i = 8'h00;
  logic [7:0]  wdata_i = 8'h00;
  logic        wr_i = 1'b0;
  logic        rd_i = 1'b0;
  logic        gen = 1'b0;
  logic        gexp = 1'b0;
  logic        tick = 1'b0;
  logic [2:0]  tcnt = 3'h0;
  logic [95:0] fv = 96'h0;
  logic [95:0] line_i, line_o, line_oe_o, rise_edge_o, fall_edge_o, rs, fs;
  logic [7:0]  rdata_o;
  logic        irq_o;
  int          err_total = 0;
  int          samples_checked = 0;
  // Port 1 input-only, port 2 output-only, rest bidirectional
  sdp_port_regs #(.PORT_KIND(24'h000024)) dut (
    .clk_i(clk_i), .rst_i(rst_i), .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i),
    .rd_i(rd_i), .rdata_o(rdata_o), .guard_timer_enable_i(gen),
    .guard_timer_expired_i(gexp), .filter_tick_i(tick), .line_i(line_i),
    .line_o(line_o), .line_oe_o(line_oe_o), .rise_edge_o(rise_edge_o),
    .fall_edge_o(fall_edge_o), .irq_o(irq_o));
  sdp_field_model u_field (.line_o(line_o), .line_oe_o(line_oe_o), .field_val(fv),
    .line_i(line_i));
  // Clock, and a filter tick every eight cycles
  always #25 clk_i = ~clk_i;
  always @(posedge clk_i) begin
    tcnt <= tcnt + 3'h1;
    tick <= (tcnt == 3'h0);
  end
  // Write, then an idle cycle so strobes never collide in one step
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    addr_i <= a;
    wdata_i <= d;
    wr_i <= 1'b1;
    @(posedge clk_i);
    wr_i <= 1'b0;
    @(posedge clk_i);
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    addr_i <= a;
    rd_i <= 1'b1;
    @(posedge clk_i);
    rd_i <= 1'b0;
    #1 d = rdata_o;
    @(posedge clk_i);
  endtask
  task automatic chk(input string n, input logic [95:0] got, input logic [95:0] exp);
    samples_checked++;
    if (got !== exp) begin
      err_total++;
      $display("[FAIL] %s expected %h seen %h", n, exp, got);
    end
  endtask
  // Gather edge pulses over n cycles
  // Sampled mid-cycle, where each one-cycle pulse has settled
  task automatic watch(input int n);
    rs = 96'h0;
    fs = 96'h0;
    repeat (n) begin
      @(negedge clk_i);
      rs |= rise_edge_o;
      fs |= fall_edge_o;
    end
    @(posedge clk_i);
  endtask
  task automatic summarize;
    $display("checks %0d mismatches %0d", samples_checked, err_total);
    if (err_total == 0 && samples_checked > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  task automatic t_reset;
    logic [7:0] d;
    for (int o = 0; o < 9; o++) begin
      if (o != 5) begin
        rd(8'hf0 + 8'(o), d);
        chk("reset reg", d, 8'h00);
      end
    end
    chk("fixed out", line_oe_o[23:16], 8'hff);
    $display("t_reset done");
  endtask
  task automatic t_data_io;
    logic [7:0] d;
    wr(8'h41, 8'h01);
    wr(8'h40, 8'ha5);
    repeat (3) @(posedge clk_i);
    chk("oe", line_oe_o[7:0], 8'hff);
    rd(8'h40, d);
    chk("pin", d, 8'ha5);
    wr(8'h41, 8'h00);
    fv[7:0] <= 8'h3c;
    repeat (4) @(posedge clk_i);
    chk("oe off", line_oe_o[7:0], 8'h00);
    rd(8'h40, d);
    chk("field", d, 8'h3c);
    $display("t_data_io done");
  endtask
  task automatic t_edges;
    logic [7:0] d;
    fv[7:0] <= 8'h00;
    repeat (8) @(posedge clk_i);
    wr(8'h42, 8'h0f);
    wr(8'h43, 8'hf0);
    wr(8'h03, 8'h03);
    wr(8'h05, 8'h07);
    fv[7:0] <= 8'hff;
    watch(10);
    chk("rise", {rs[7:0], fs[7:0]}, 16'h0f00);
    chk("irq", irq_o, 1'b1);
    fv[7:0] <= 8'h00;
    watch(10);
    chk("fall", {rs[7:0], fs[7:0]}, 16'h00f0);
    rd(8'h02, d);
    chk("status", d, 8'h03);
    wr(8'h03, 8'h00);
    chk("irq masked", irq_o, 1'b0);
    wr(8'h05, 8'h03);
    rd(8'h02, d);
    chk("status clr", d, 8'h00);
    $display("t_edges done");
  endtask
  // One-cycle glitch on lines 0 and 1, only line 0 filtered
  task automatic t_filter;
    wr(8'h44, 8'h01);
    fv[1:0] <= 2'b11;
    @(posedge clk_i);
    fv[1:0] <= 2'b00;
    watch(30);
    chk("glitch", rs[1:0], 2'b10);
    fv[0] <= 1'b1;
    watch(40);
    chk("stable", rs[0], 1'b1);
    fv[0] <= 1'b0;
    wr(8'h44, 8'h00);
    $display("t_filter done");
  endtask
  task automatic t_expiry;
    logic [7:0] d;
    wr(8'h41, 8'h01);
    wr(8'h40, 8'h5a);
    wr(8'h47, 8'h01);
    wr(8'h48, 8'hc3);
    wr(8'h71, 8'h01);
    wr(8'h76, 8'h01);
    wr(8'h77, 8'h01);
    wr(8'h57, 8'h01);
    wr(8'h66, 8'h01);
    wr(8'h67, 8'h01);
    wr(8'h68, 8'h81);
    gexp <= 1'b1;
    repeat (8) @(posedge clk_i);
    chk("no enable", line_o[7:0], 8'h5a);
    rd(8'h02, d);
    chk("no exp event", d[2], 1'b0);
    gen <= 1'b1;
    repeat (8) @(posedge clk_i);
    chk("levels", {line_oe_o[7:0], line_o[7:0]}, 16'hffc3);
    chk("high z", line_oe_o[31:24], 8'h00);
    chk("input port", line_oe_o[15:8], 8'h00);
    chk("out port", {line_oe_o[23:16], line_o[23:16]}, 16'hff81);
    rd(8'h17, d);
    chk("exp status", d, 8'h01);
    rd(8'h02, d);
    chk("exp event", d[2], 1'b1);
    gexp <= 1'b0;
    repeat (8) @(posedge clk_i);
    chk("holds", line_o[7:0], 8'hc3);
    wr(8'h01, 8'h10);
    repeat (4) @(posedge clk_i);
    chk("restored", line_o[7:0], 8'h5a);
    rd(8'h17, d);
    chk("exp cleared", d, 8'h00);
    gen <= 1'b0;
    $display("t_expiry done");
  endtask
  // Write all ports, read all back, then clear; catches aliasing
  task automatic t_regs;
    logic [7:0] a, v, d;
    for (int m = 0; m < 3; m++)
      for (int p = 0; p < 12; p++)
        for (int o = 2; o < 9; o++) begin
          a = 8'h40 + 8'(16 * p + o);
          v = (o == 6 || o == 7) ? 8'(p % 2) : 8'(16 * p + o);
          if (m == 0)
            wr(a, v);
          else if (m == 2)
            wr(a, 8'h00);
          else begin
            rd(a, d);
            chk("readback", d, (o == 5) ? 8'h00 : v);
          end
        end
    $display("t_regs done");
  endtask
  initial begin
    repeat (4) @(posedge clk_i);
    rst_i <= 1'b0;
    t_reset;
    t_data_io;
    t_edges;
    t_filter;
    t_expiry;
    t_regs;
    summarize;
  end
  // About eleven times the expected run length
  initial begin
    #400000;
    err_total++;
    summarize;
  end
endmodule // sdp_port_regs_tb
`default_nettype wire
